// ===== include/coef_bank_defs.vh
// Constants for the channel B equalizer coefficient register bank.
// Assumes a 32-bit APB slave where each register takes one aligned word.
`ifndef COEF_BANK_DEFS_VH
`define COEF_BANK_DEFS_VH

// Register indices (printed offsets are not all multiples of four).
`define TAP1_IDX        12'h448
`define TAP2_IDX        12'h44a
`define TAP3_IDX        12'h44c
`define TAP4_IDX        12'h44e
`define CENTER_IDX      12'h450
`define CTRL_IDX        12'h460
`define STATUS_IDX      12'h461

// Byte addresses are four times the index.
`define TAP1_ADDR       14'h1120
`define TAP2_ADDR       14'h1128
`define TAP3_ADDR       14'h1130
`define TAP4_ADDR       14'h1138
`define CENTER_ADDR     14'h1140
`define CTRL_ADDR       14'h1180
`define STATUS_ADDR     14'h1184

// Field layouts.
`define EDGE_REG_W      16
`define EDGE_COEF_W     12
`define CENTER_REG_W    24
`define CENTER_COEF_W   18
`define COEF_RESET      24'h000000
`define CTRL_DUAL_BIT   0
`define CTRL_RESET      1'h0

`endif

// ===== verification/fir_b_coef_bank_asserts.sv
// Port-level assertions for the channel B coefficient bank.
// Bound to every fir_b_coef_bank instance; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Checker.
module fir_b_coef_bank_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] tap1_coef,
    input wire logic [11:0] tap2_coef,
    input wire logic [11:0] tap3_coef,
    input wire logic [11:0] tap4_coef,
    input wire logic [17:0] center_coef,
    input wire logic        dual_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd_done = pready && !pwrite && !pslverr;
    wire wr_dual = pready && pwrite && dual_active;
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |-> psel && penable && !$past(pready))
        else $error("ready outside one access cycle");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_edge_msb_zero: assert property (rd_done && paddr >= 16'h1120 && paddr <= 16'h1138
        |-> !prdata[11] && prdata[31:16] == 16'h0) else $error("edge tap readback");
    a_center_msb_zero: assert property (rd_done && paddr == 16'h1140
        |-> !prdata[17] && prdata[31:24] == 8'h0) else $error("centre readback");
    a_bad_addr_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
        else $error("misaligned access accepted");
    a_single_zero: assert property (!dual_active && !$past(dual_active) && !$past(dual_active, 2)
        |-> {center_coef, tap4_coef, tap3_coef, tap2_coef, tap1_coef} == 66'h0) else $error("taps live");
    a_tap1_load: assert property (wr_dual && paddr == 16'h1120
        |-> ##2 tap1_coef == $past(pwdata[11:0], 2)) else $error("tap one not applied");
    a_center_load: assert property (wr_dual && paddr == 16'h1140
        |-> ##2 center_coef == $past(pwdata[17:0], 2)) else $error("centre not applied");
endmodule // fir_b_coef_bank_asserts

bind fir_b_coef_bank fir_b_coef_bank_asserts fir_b_coef_bank_asserts_i (.*);
`default_nettype wire

// ===== verification/fir_b_coef_bank_tb.sv
// Self-checking bench for the channel B coefficient bank.
// Drives the APB port directly; the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench.
module fir_b_coef_bank_tb;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        err;
    wire  [31:0] prdata;
    wire         pready, pslverr, dual_active;
    wire  [11:0] tap1_coef, tap2_coef, tap3_coef, tap4_coef;
    wire  [17:0] center_coef;
    wire  [65:0] taps = {center_coef, tap4_coef, tap3_coef, tap2_coef, tap1_coef};
    int          n_errors = 0;
    int          compares = 0;
    logic [15:0] edge_a [4] = '{16'h1120, 16'h1128, 16'h1130, 16'h1138};

    always #12.5 clk = ~clk;

    fir_b_coef_bank fir_b_coef_bank_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tap1_coef(tap1_coef), .tap2_coef(tap2_coef), .tap3_coef(tap3_coef),
        .tap4_coef(tap4_coef), .center_coef(center_coef), .dual_active(dual_active));

    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for pready however long the slave takes, bounded only by the watchdog.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk({err, rd}, {1'b0, exp});
    endtask

    task automatic t_reset;
        for (int i = 0; i < 4; i++) rdchk(edge_a[i], 32'h0);
        rdchk(16'h1140, 32'h0);
        chk(taps, 66'h0);
        $display("reset values done");
    endtask

    task automatic t_single;
        for (int i = 0; i < 4; i++) apb(1'b1, edge_a[i], {16'h5a5a, 12'hf8a, i[3:0]});
        apb(1'b1, 16'h1140, 32'hfffea5c3);
        for (int i = 0; i < 4; i++) rdchk(edge_a[i], {16'h0, 12'hf0a, i[3:0]});
        rdchk(16'h1140, 32'h00fca5c3);
        chk(taps, 66'h0);
        $display("single mode done");
    endtask

    task automatic t_dual;
        apb(1'b1, 16'h1180, 32'h1);
        rdchk(16'h1180, 32'h1);
        rdchk(16'h1184, 32'h1);
        chk(dual_active, 1'b1);
        chk(taps, {18'h2a5c3, 12'h8a3, 12'h8a2, 12'h8a1, 12'h8a0});
        apb(1'b1, 16'h1120, 32'h0000f7ff);
        apb(1'b1, 16'h1140, 32'h00c1ffff);
        repeat (2) @(posedge clk);
        chk(taps, {18'h1ffff, 12'h8a3, 12'h8a2, 12'h8a1, 12'h7ff});
        $display("dual mode done");
    endtask

    task automatic t_err;
        apb(1'b1, 16'h1121, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 16'h1144, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        rdchk(16'h1120, 32'h0000f7ff);
        apb(1'b1, 16'h1180, 32'h0);
        repeat (3) @(posedge clk);
        chk(taps, 66'h0);
        chk(dual_active, 1'b0);
        rdchk(16'h1184, 32'h0);
        $display("errors and mode off done");
    endtask

    task automatic finish_test;
        $display("compares=%0d errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_single;
        t_dual;
        t_err;
        finish_test;
    end

    initial
    begin
        #50000;
        n_errors++;
        finish_test;
    end
endmodule // fir_b_coef_bank_tb
`default_nettype wire

// ===== verilog/coef_reg.v
// One coefficient register with readback and filter-facing views.
// Assumes a write strobe on the same clock and an active low synchronised reset.
`timescale 1ns/10ps
`default_nettype none

module coef_reg #(
    parameter REG_W  = 16,
    parameter COEF_W = 12
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire              wr_en,
    input  wire [REG_W-1:0]  wr_data,
    output wire [REG_W-1:0]  rd_data,
    output wire [COEF_W-1:0] coef
);

    reg [REG_W-1:0] value_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value_q <= {REG_W{1'b0}};
        else if (wr_en)
            value_q <= wr_data;
    end

    // The coefficient sign bit always reads back as zero.
    assign rd_data = {value_q[REG_W-1:COEF_W], 1'b0, value_q[COEF_W-2:0]};
    assign coef    = value_q[COEF_W-1:0];

endmodule // coef_reg

`default_nettype wire

// ===== verilog/fir_b_coef_bank.v
// APB register bank holding channel B taps one to five of the equalizer filter.
// Assumes an APB master on clk; coefficient outputs feed the filter datapath.
//
// Notes on behaviour
// - Each stored tap is a signed two's-complement value in the register's low field, bits 11:0 for edge taps.
// - A read returns the stored value except that the coefficient's top bit always reads as zero.
// - In dual-channel mode the first register of the set drives tap one of channel B.
// - In dual-channel mode the register at 0x44a drives tap two of channel B.
// - In dual-channel mode the register at 0x44c drives tap three of channel B.
// - In dual-channel mode the register at 0x44e drives tap four of channel B.
// - In dual-channel mode the register at 0x450 drives tap five, the centre of the nine taps.
// - The centre coefficient is 18 bits, bits 17:0 of a 24-bit register with 23:18 reserved.
// - After reset every register of the set, reserved bits included, holds zero.
// - The first coefficient lives at 0x448 and resets to zero.
// - In single-channel mode this set is unused and channel B taps are held at zero.
`timescale 1ns/10ps
`default_nettype none
`include "coef_bank_defs.vh"

module fir_b_coef_bank (
    input  wire        clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [11:0] tap1_coef,
    output reg  [11:0] tap2_coef,
    output reg  [11:0] tap3_coef,
    output reg  [11:0] tap4_coef,
    output reg  [17:0] center_coef,
    output reg         dual_active
);

    // ==========================================================
    // Reset synchroniser
    // ==========================================================
    // Both flops clear together; the internal copy rises two edges after resetn.
    reg rst_meta_q;
    reg rst_n_q;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ==========================================================
    // Address decode
    // ==========================================================
    // One-hot target select: bit positions of the decoded register.
    localparam SEL_TAP1   = 0;
    localparam SEL_TAP2   = 1;
    localparam SEL_TAP3   = 2;
    localparam SEL_TAP4   = 3;
    localparam SEL_CENTER = 4;
    localparam SEL_CTRL   = 5;
    localparam SEL_STATUS = 6;
    localparam SEL_W      = 7;

    wire             setup_phase = psel && !penable;
    wire             word_ok     = (paddr[1:0] == 2'b00);
    wire [13:0]      waddr       = paddr[15:2];
    reg  [SEL_W-1:0] sel;

    // Only a word-aligned address picks a register; anything else is refused.
    always @*
    begin
        sel = {SEL_W{1'b0}};
        if (word_ok)
        begin
            case (waddr)
                {2'b00, `TAP1_IDX}:   sel[SEL_TAP1]   = 1'b1;
                {2'b00, `TAP2_IDX}:   sel[SEL_TAP2]   = 1'b1;
                {2'b00, `TAP3_IDX}:   sel[SEL_TAP3]   = 1'b1;
                {2'b00, `TAP4_IDX}:   sel[SEL_TAP4]   = 1'b1;
                {2'b00, `CENTER_IDX}: sel[SEL_CENTER] = 1'b1;
                {2'b00, `CTRL_IDX}:   sel[SEL_CTRL]   = 1'b1;
                {2'b00, `STATUS_IDX}: sel[SEL_STATUS] = 1'b1;
                default:              sel = {SEL_W{1'b0}};
            endcase
        end
    end

    // Named views of the select vector keep the strobes below readable.
    wire hit_tap1   = sel[SEL_TAP1];
    wire hit_tap2   = sel[SEL_TAP2];
    wire hit_tap3   = sel[SEL_TAP3];
    wire hit_tap4   = sel[SEL_TAP4];
    wire hit_center = sel[SEL_CENTER];
    wire hit_ctrl   = sel[SEL_CTRL];
    wire hit_status = sel[SEL_STATUS];
    wire hit_any    = |sel;

    // Writes commit in the access phase, the single cycle pready is high.
    wire        wr_fire     = psel && penable && pready && pwrite;

    // ==========================================================
    // Coefficient storage
    // ==========================================================
    wire [15:0] rd_tap1;
    wire [15:0] rd_tap2;
    wire [15:0] rd_tap3;
    wire [15:0] rd_tap4;
    wire [23:0] rd_center;
    wire [11:0] val_tap1;
    wire [11:0] val_tap2;
    wire [11:0] val_tap3;
    wire [11:0] val_tap4;
    wire [17:0] val_center;

    coef_reg #(.REG_W(`EDGE_REG_W), .COEF_W(`EDGE_COEF_W)) u_tap1 (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (wr_fire && hit_tap1),
        .wr_data (pwdata[15:0]),
        .rd_data (rd_tap1),
        .coef    (val_tap1)
    );

    coef_reg #(.REG_W(`EDGE_REG_W), .COEF_W(`EDGE_COEF_W)) u_tap2 (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (wr_fire && hit_tap2),
        .wr_data (pwdata[15:0]),
        .rd_data (rd_tap2),
        .coef    (val_tap2)
    );

    coef_reg #(.REG_W(`EDGE_REG_W), .COEF_W(`EDGE_COEF_W)) u_tap3 (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (wr_fire && hit_tap3),
        .wr_data (pwdata[15:0]),
        .rd_data (rd_tap3),
        .coef    (val_tap3)
    );

    coef_reg #(.REG_W(`EDGE_REG_W), .COEF_W(`EDGE_COEF_W)) u_tap4 (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (wr_fire && hit_tap4),
        .wr_data (pwdata[15:0]),
        .rd_data (rd_tap4),
        .coef    (val_tap4)
    );

    coef_reg #(.REG_W(`CENTER_REG_W), .COEF_W(`CENTER_COEF_W)) u_center (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (wr_fire && hit_center),
        .wr_data (pwdata[23:0]),
        .rd_data (rd_center),
        .coef    (val_center)
    );

    // ==========================================================
    // Mode control
    // ==========================================================
    reg dual_q;

    always @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            dual_q <= `CTRL_RESET;
        else if (wr_fire && hit_ctrl)
            dual_q <= pwdata[`CTRL_DUAL_BIT];
    end

    // ==========================================================
    // Filter-facing coefficients
    // ==========================================================
    // Taps are registered so the datapath sees a glitch-free value.
    // In single-channel mode the datapath sees zero taps from this set.
    always @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tap1_coef   <= 12'h000;
            tap2_coef   <= 12'h000;
            tap3_coef   <= 12'h000;
            tap4_coef   <= 12'h000;
            center_coef <= 18'h00000;
            dual_active <= 1'b0;
        end
        else if (dual_q)
        begin
            tap1_coef   <= val_tap1;
            tap2_coef   <= val_tap2;
            tap3_coef   <= val_tap3;
            tap4_coef   <= val_tap4;
            center_coef <= val_center;
            dual_active <= 1'b1;
        end
        else
        begin
            tap1_coef   <= 12'h000;
            tap2_coef   <= 12'h000;
            tap3_coef   <= 12'h000;
            tap4_coef   <= 12'h000;
            center_coef <= 18'h00000;
            dual_active <= 1'b0;
        end
    end

    // ==========================================================
    // Handshake state
    // ==========================================================
    // A transfer is answered in its first access cycle, so the slave never
    // stretches it; a back-to-back setup is taken from the idle state.
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RESP = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;

    always @*
    begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE:
            begin
                if (setup_phase)
                    state_d = ST_RESP;
                else
                    state_d = ST_IDLE;
            end
            ST_RESP:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Read data select
    // ==========================================================
    // Refused addresses read as zero.
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = 32'h00000000;
        case (1'b1)
            hit_tap1:   rd_mux = {16'h0000, rd_tap1};
            hit_tap2:   rd_mux = {16'h0000, rd_tap2};
            hit_tap3:   rd_mux = {16'h0000, rd_tap3};
            hit_tap4:   rd_mux = {16'h0000, rd_tap4};
            hit_center: rd_mux = {8'h00, rd_center};
            hit_ctrl:   rd_mux = {31'h00000000, dual_q};
            hit_status: rd_mux = {31'h00000000, dual_active};
            default:    rd_mux = 32'h00000000;
        endcase
    end

    // ==========================================================
    // APB response
    // ==========================================================
    // No wait states: pready rises in the first access cycle.
    always @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (state_d == ST_RESP)
        begin
            pready  <= 1'b1;
            pslverr <= !hit_any;
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

endmodule // fir_b_coef_bank

`default_nettype wire
